// ==== lpc_ctrl_model.sv ====
`timescale 1ns/1ps
module lpc_ctrl_model #(
	parameter int TCKE = 3
) (
	input wire logic mclk_i,
	output lpc_pkg::lpc_cmd_t cmd_o
);
	initial cmd_o = {1'b1, 1'b1, 10'h155};
	// Deselected CA lines toggle so a stale value never reads as a command
	task automatic step(input logic cke, input logic cs_n, input logic [9:0] ca);
		@(negedge mclk_i);
		cmd_o <= {cke, cs_n, cs_n ? ~cmd_o.ca : ca};
	endtask
	task automatic enter(input logic cs_n, input logic [2:0] op);
		step(1'b1, 1'b1, 10'h0);
		step(1'b0, cs_n, {7'h0, op});
		step(1'b0, 1'b1, 10'h0);
		repeat (TCKE) step(1'b0, 1'b1, 10'h0);
	endtask
	task automatic leave();
		step(1'b1, 1'b1, 10'h0);
		repeat (TCKE) step(1'b1, 1'b1, 10'h0);
	endtask
endmodule

// ==== lpc_decode.sv ====
`timescale 1ns/1ps
module lpc_decode (
	input wire lpc_pkg::lpc_cmd_t cmd_i,
	input wire logic cke_prev_i,
	output logic pd_entry_o,
	output logic dpd_entry_o,
	output logic nop_o,
	output logic exit_o
);
	always_comb begin
		// Enable high in the prior cycle, low now, chip select high
		pd_entry_o = cke_prev_i && !cmd_i.cke && cmd_i.cs_n;
		dpd_entry_o = cke_prev_i && !cmd_i.cke && !cmd_i.cs_n && cmd_i.ca[lpc_pkg::CA0_POS]
			&& cmd_i.ca[lpc_pkg::CA1_POS] && !cmd_i.ca[lpc_pkg::CA2_POS];
		nop_o = cmd_i.cs_n || (cmd_i.ca[lpc_pkg::CA0_POS] && cmd_i.ca[lpc_pkg::CA1_POS]
			&& cmd_i.ca[lpc_pkg::CA2_POS]);
		exit_o = !cke_prev_i && cmd_i.cke;
	end
endmodule

// ==== lpc_pkg.sv ====
package lpc_pkg;

	localparam int CLK_PERIOD_NS = 25;

	// Power-down exit latency, printed in ns; count rounds up
	localparam int T_XP_NS = 8;
	localparam int T_XP_CYC = (T_XP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Valid clock periods needed after a clock stop with enable high
	localparam int CLK_RESTART_CYC = 2;
	localparam int READY_CYC = CLK_RESTART_CYC + T_XP_CYC;
	localparam int CNT_W = 4;

	localparam int NUM_BANKS = 4;

	// Command bus bit positions
	localparam int CA0_POS = 0;
	localparam int CA1_POS = 1;
	localparam int CA2_POS = 2;

	typedef enum logic [2:0] {
		LPC_ACTIVE,
		LPC_PD_IDLE,
		LPC_PD_ACT,
		LPC_DPD,
		LPC_EXIT_WAIT
	} lpc_state_t;

	typedef struct packed {
		logic cke;
		logic cs_n;
		logic [9:0] ca;
	} lpc_cmd_t;

	typedef struct packed {
		logic in_buf_en;
		logic out_buf_en;
		logic core_pwr_en;
		logic array_valid;
	} lpc_pwr_t;

endpackage

// ==== lpc_power_ctrl.sv ====
`timescale 1ns/1ps
module lpc_power_ctrl (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic [9:0] ca_i,
	input wire logic [lpc_pkg::NUM_BANKS-1:0] bank_open_i,
	input wire logic core_busy_i,
	input wire logic clk_change_i,
	input wire logic init_done_i,
	output logic [2:0] state_o,
	output logic pd_active_o,
	output logic low_power_o,
	output logic in_buf_en_o,
	output logic out_buf_en_o,
	output logic core_pwr_en_o,
	output logic array_valid_o,
	output logic need_init_o,
	output logic cmd_valid_o,
	output logic ready_o
);
	lpc_pkg::lpc_cmd_t cmd_s1_r, cmd_r;
	lpc_pkg::lpc_state_t state_r, state_nxt;
	logic cke_prev_r;
	logic pd_entry, dpd_entry, nop, pd_exit;
	logic [lpc_pkg::CNT_W-1:0] cnt_r;
	logic clk_chg_s1_r, clk_chg_r;
	logic busy_s1_r, busy_r;
	logic [lpc_pkg::NUM_BANKS-1:0] bank_s1_r, bank_r;
	logic init_s1_r, init_r;

	// Pins are asynchronous to this clock; two stages before any logic
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cmd_s1_r <= '{cke: 1'b0, cs_n: 1'b1, ca: 10'h3ff};
			cmd_r <= '{cke: 1'b0, cs_n: 1'b1, ca: 10'h3ff};
			clk_chg_s1_r <= 1'b0;
			clk_chg_r <= 1'b0;
			busy_s1_r <= 1'b0;
			busy_r <= 1'b0;
			bank_s1_r <= '0;
			bank_r <= '0;
			init_s1_r <= 1'b0;
			init_r <= 1'b0;
		end else if (ce_i) begin
			cmd_s1_r <= '{cke: cke_i, cs_n: cs_n_i, ca: ca_i};
			cmd_r <= cmd_s1_r;
			clk_chg_s1_r <= clk_change_i;
			clk_chg_r <= clk_chg_s1_r;
			busy_s1_r <= core_busy_i;
			busy_r <= busy_s1_r;
			bank_s1_r <= bank_open_i;
			bank_r <= bank_s1_r;
			init_s1_r <= init_done_i;
			init_r <= init_s1_r;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cke_prev_r <= 1'b0;
		end else if (ce_i) begin
			cke_prev_r <= cmd_r.cke;
		end
	end

	lpc_decode u_dec (
		.cmd_i(cmd_r),
		.cke_prev_i(cke_prev_r),
		.pd_entry_o(pd_entry),
		.dpd_entry_o(dpd_entry),
		.nop_o(nop),
		.exit_o(pd_exit)
	);

	function automatic logic [lpc_pkg::CNT_W-1:0] cyc(input int n);
		cyc = n[lpc_pkg::CNT_W-1:0];
	endfunction

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			lpc_pkg::LPC_ACTIVE: begin
				if (dpd_entry) begin
					state_nxt = lpc_pkg::LPC_DPD;
				end else if (pd_entry) begin
					// Banks with open rows give active power-down
					state_nxt = (|bank_r) ? lpc_pkg::LPC_PD_ACT : lpc_pkg::LPC_PD_IDLE;
				end
			end
			lpc_pkg::LPC_PD_IDLE, lpc_pkg::LPC_PD_ACT: begin
				if (pd_exit) begin
					state_nxt = lpc_pkg::LPC_EXIT_WAIT;
				end
			end
			lpc_pkg::LPC_DPD: begin
				if (pd_exit) begin
					state_nxt = lpc_pkg::LPC_EXIT_WAIT;
				end
			end
			lpc_pkg::LPC_EXIT_WAIT: begin
				if (cnt_r == '0 && !need_init_o) begin
					state_nxt = lpc_pkg::LPC_ACTIVE;
				end else if (cnt_r == '0 && init_r) begin
					state_nxt = lpc_pkg::LPC_ACTIVE;
				end
			end
			default: state_nxt = lpc_pkg::LPC_ACTIVE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_r <= lpc_pkg::LPC_ACTIVE;
		end else if (ce_i) begin
			state_r <= state_nxt;
		end
	end

	// Exit latency counter; also covers the clock restart window
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cnt_r <= '0;
		end else if (ce_i) begin
			if (clk_chg_r) begin
				cnt_r <= cyc(lpc_pkg::READY_CYC);
			end else if (state_nxt == lpc_pkg::LPC_EXIT_WAIT && state_r != lpc_pkg::LPC_EXIT_WAIT) begin
				cnt_r <= cyc(lpc_pkg::T_XP_CYC);
			end else if (cnt_r != '0) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	// Array contents lost on deep power-down; re-init clears need_init_o, array_valid_o stays low until reset
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			need_init_o <= 1'b0;
			array_valid_o <= 1'b1;
		end else if (ce_i) begin
			if (state_nxt == lpc_pkg::LPC_DPD) begin
				need_init_o <= 1'b1;
				array_valid_o <= 1'b0;
			end else if (need_init_o && init_r && state_r == lpc_pkg::LPC_EXIT_WAIT) begin
				need_init_o <= 1'b0;
			end
		end
	end

	// Low-power current only once pending row or refresh work finishes
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			low_power_o <= 1'b0;
		end else if (ce_i) begin
			low_power_o <= (state_nxt == lpc_pkg::LPC_PD_IDLE || state_nxt == lpc_pkg::LPC_PD_ACT
				|| state_nxt == lpc_pkg::LPC_DPD) && !busy_r;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_o <= lpc_pkg::LPC_ACTIVE;
			pd_active_o <= 1'b0;
		end else if (ce_i) begin
			state_o <= state_nxt;
			pd_active_o <= state_nxt == lpc_pkg::LPC_PD_ACT;
		end
	end

	// Buffers off while powered down; core power stays on except in deep power-down
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			in_buf_en_o <= 1'b1;
			out_buf_en_o <= 1'b1;
			core_pwr_en_o <= 1'b1;
		end else if (ce_i) begin
			in_buf_en_o <= state_nxt == lpc_pkg::LPC_ACTIVE
				|| state_nxt == lpc_pkg::LPC_EXIT_WAIT;
			out_buf_en_o <= state_nxt == lpc_pkg::LPC_ACTIVE
				|| state_nxt == lpc_pkg::LPC_EXIT_WAIT;
			core_pwr_en_o <= state_nxt != lpc_pkg::LPC_DPD;
		end
	end

	// Non-NOP commands pass only when active and enable steady
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cmd_valid_o <= 1'b0;
		end else if (ce_i) begin
			cmd_valid_o <= state_r == lpc_pkg::LPC_ACTIVE && state_nxt == lpc_pkg::LPC_ACTIVE
				&& cnt_r == '0 && cmd_r.cke && cke_prev_r && !nop;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ready_o <= 1'b0;
		end else if (ce_i) begin
			ready_o <= state_nxt == lpc_pkg::LPC_ACTIVE && cnt_r == '0 && !clk_chg_r;
		end
	end
endmodule

// ==== lpc_power_ctrl_checker.sv ====
`timescale 1ns/1ps
module lpc_chk (
	input wire logic mclk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic cke_i,
	input wire logic cs_n_i,
	input wire logic [9:0] ca_i,
	input wire logic [lpc_pkg::NUM_BANKS-1:0] bank_open_i,
	input wire logic core_busy_i,
	input wire logic [2:0] state_o,
	input wire logic pd_active_o,
	input wire logic low_power_o,
	input wire logic in_buf_en_o,
	input wire logic core_pwr_en_o,
	input wire logic array_valid_o,
	input wire logic need_init_o,
	input wire logic cmd_valid_o
);
	default clocking @(posedge mclk_i); endclocking
	// Frozen cycles break every timing below, so they void the attempt
	default disable iff (reset_i || !ce_i);
	property p_idle; state_o == 3'h0 && $fell(cke_i) && cs_n_i && bank_open_i == '0 ##1 !cke_i [*4] |-> state_o == 3'h1; endproperty
	a_idle: assert property (p_idle) else $error("idle power-down not entered");
	property p_act; state_o == 3'h0 && $fell(cke_i) && cs_n_i && bank_open_i != '0 ##1 !cke_i [*4] |-> state_o == 3'h2 && pd_active_o; endproperty
	a_act: assert property (p_act) else $error("active power-down not entered");
	property p_deep; state_o == 3'h0 && $fell(cke_i) && !cs_n_i && ca_i[2:0] == 3'h3 ##1 !cke_i [*4] |-> state_o == 3'h3; endproperty
	a_deep: assert property (p_deep) else $error("deep power-down not entered");
	property p_buf; state_o inside {3'h1, 3'h2, 3'h3} |-> !in_buf_en_o; endproperty
	a_buf: assert property (p_buf) else $error("input buffers on in power-down");
	property p_loss; state_o == 3'h3 |-> !core_pwr_en_o && !array_valid_o && need_init_o; endproperty
	a_loss: assert property (p_loss) else $error("deep power-down outputs wrong");
	property p_wake; state_o inside {3'h1, 3'h2} && cke_i ##1 cke_i [*4] |-> !(state_o inside {3'h1, 3'h2}); endproperty
	a_wake: assert property (p_wake) else $error("power-down not left");
	property p_nop; (cke_i && (cs_n_i || ca_i[2:0] == 3'h7)) [*5] |-> !cmd_valid_o; endproperty
	a_nop: assert property (p_nop) else $error("no-operation taken as command");
	property p_busy; (state_o inside {3'h1, 3'h2} && core_busy_i) [*3] |-> !low_power_o; endproperty
	a_busy: assert property (p_busy) else $error("low power while core busy");
endmodule
bind lpc_power_ctrl lpc_chk u_chk (.mclk_i, .reset_i, .ce_i, .cke_i, .cs_n_i, .ca_i, .bank_open_i,
	.core_busy_i, .state_o, .pd_active_o, .low_power_o, .in_buf_en_o, .core_pwr_en_o,
	.array_valid_o, .need_init_o, .cmd_valid_o);

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] bank = 4'h0;
	logic busy = 1'b0, chg = 1'b0, initd = 1'b1, ce = 1'b1, stop = 1'b0;
	lpc_pkg::lpc_cmd_t cmd;
	logic [2:0] st;
	logic pda, lp, ib, ob, cp, av, ni, cv, rdy;
	int miscompares = 0, n_compared = 0, cyc = 0;
	always #12.5 mclk_i = stop ? 1'b0 : ~mclk_i;
	lpc_ctrl_model #(.TCKE(3)) model (.mclk_i(mclk_i), .cmd_o(cmd));
	lpc_power_ctrl uut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce), .cke_i(cmd.cke),
		.cs_n_i(cmd.cs_n), .ca_i(cmd.ca), .bank_open_i(bank), .core_busy_i(busy),
		.clk_change_i(chg), .init_done_i(initd), .state_o(st), .pd_active_o(pda),
		.low_power_o(lp), .in_buf_en_o(ib), .out_buf_en_o(ob), .core_pwr_en_o(cp),
		.array_valid_o(av), .need_init_o(ni), .cmd_valid_o(cv), .ready_o(rdy));
	task automatic test_done();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [3:0] got, input logic [3:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wst(input logic [2:0] s);
		for (int i = 0; i < 20 && st !== s; i++) @(negedge mclk_i);
		chk({1'b0, st}, {1'b0, s});
	endtask
	task automatic wrd();
		for (int i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge mclk_i);
		chk({st, rdy}, 4'h1);
	endtask
	task automatic mon(input logic [9:0] ca, output logic seen);
		seen = 1'b0;
		fork
			begin
				model.step(1'b1, 1'b0, ca);
				model.step(1'b1, 1'b0, ca);
				model.step(1'b1, 1'b1, 10'h0);
			end
			repeat (8) @(negedge mclk_i) seen |= cv;
		join
	endtask
	task automatic t_idle();
		model.enter(1'b1, 3'h0);
		wst(3'h1);
		chk({ib, ob, cp, av}, 4'h3);
		model.leave();
		wrd();
		$display("idle power-down done");
	endtask
	task automatic t_act();
		bank = 4'h5;
		busy = 1'b1;
		model.enter(1'b1, 3'h0);
		wst(3'h2);
		repeat (3) @(negedge mclk_i);
		chk({pda, lp, ib, 1'b0}, 4'h8);
		busy = 1'b0;
		for (int i = 0; i < 10 && lp !== 1'b1; i++) @(negedge mclk_i);
		chk({3'h0, lp}, 4'h1);
		model.leave();
		wrd();
		bank = 4'h0;
		$display("active power-down done");
	endtask
	task automatic t_dpd();
		initd = 1'b0;
		model.enter(1'b0, 3'h3);
		wst(3'h3);
		chk({cp, av, ni, ib}, 4'h2);
		model.leave();
		repeat (6) @(negedge mclk_i);
		chk({av, st}, 4'h4);
		initd = 1'b1;
		wrd();
		chk({3'h0, av}, 4'h0);
		$display("deep power-down done");
	endtask
	task automatic t_cmd();
		logic seen;
		mon(10'h3ff, seen);
		chk({3'h0, seen}, 4'h0);
		mon(10'h000, seen);
		chk({3'h0, seen}, 4'h1);
		$display("no-operation done");
	endtask
	task automatic t_clk();
		chg = 1'b1;
		repeat (4) @(negedge mclk_i);
		chk({3'h0, rdy}, 4'h0);
		stop = 1'b1;
		#110;
		stop = 1'b0;
		@(negedge mclk_i);
		chg = 1'b0;
		@(negedge mclk_i);
		chk({3'h0, rdy}, 4'h0);
		wrd();
		$display("clock change done");
	endtask
	task automatic t_ce();
		ce = 1'b0;
		model.enter(1'b1, 3'h0);
		chk({1'b0, st}, 4'h0);
		ce = 1'b1;
		wst(3'h1);
		model.leave();
		wrd();
		$display("clock enable hold done");
	endtask
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		repeat (16) @(negedge mclk_i);
		reset_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		t_idle();
		t_act();
		t_dpd();
		t_cmd();
		t_clk();
		t_ce();
		test_done();
	end
endmodule
